// *** hw/cpm_pkg.sv ***
package cpm_pkg;

  // apb geometry
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // register indices; byte address is four times the index
  localparam logic [9:0] REG_PLL_IDX = 10'h010;
  localparam logic [9:0] REG_DIV_IDX = 10'h1E0;
  localparam logic [9:0] REG_SRC_IDX = 10'h1E1;
  localparam logic [9:0] REG_NV_IDX = 10'h1F0;
  localparam logic [11:0] ADDR_PLL = {REG_PLL_IDX, 2'h0};
  localparam logic [11:0] ADDR_DIV = {REG_DIV_IDX, 2'h0};
  localparam logic [11:0] ADDR_SRC = {REG_SRC_IDX, 2'h0};
  localparam logic [11:0] ADDR_NV = {REG_NV_IDX, 2'h0};

  // field positions
  localparam int PLL_PWR_LSB = 0;
  localparam int PFD_POL_BIT = 7;
  localparam int DIV_LSB = 0;
  localparam int BYPASS_BIT = 0;
  localparam int NV_SAVE_BIT = 0;
  localparam int NV_LOAD_BIT = 1;
  localparam int NV_VALID_BIT = 2;
  localparam int NV_BUSY_BIT = 3;

  // reset values
  localparam logic [7:0] RST_PLL = 8'h01;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [7:0] RST_SRC = 8'h00;

  // field codes
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_ASYNC_PD = 2'h1;
  localparam logic [2:0] DIV_RATIO_BYPASS = 3'h1;
  localparam logic [2:0] DIV_RATIO_DEFAULT = 3'h2;

  // nonvolatile image: three config bytes and a marker byte
  localparam logic [1:0] NV_LAST_CFG = 2'h2;
  localparam logic [1:0] NV_MARK_IDX = 2'h3;
  localparam logic [7:0] NV_MAGIC = 8'hA5;

  typedef enum logic [1:0] {
    PLL_RUN = 2'b00,
    PLL_ASYNC_OFF = 2'b01,
    PLL_HALTED = 2'b10
  } cpm_pll_state_t;

  typedef enum logic [1:0] {
    NV_IDLE = 2'b00,
    NV_SAVE = 2'b01,
    NV_LOAD = 2'b10,
    NV_BOOT = 2'b11
  } cpm_nv_state_t;

endpackage

// *** hw/cpm_nv_store.sv ***
`timescale 1ns/1ns
module cpm_nv_store (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_valid
);
  import cpm_pkg::*;

  // models nonvolatile cells: deliberately untouched by reset
  logic [7:0] mem [0:3];

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_addr];
  assign o_valid = (mem[NV_MARK_IDX] == NV_MAGIC);
endmodule

// *** hw/cpm_mode_decode.sv ***
`timescale 1ns/1ns
module cpm_mode_decode (
  input wire logic [1:0] i_pll_power,
  input wire logic i_bypass,
  input wire logic [2:0] i_div_code,
  output cpm_pkg::cpm_pll_state_t o_pll_state,
  output logic [2:0] o_div_ratio,
  output logic o_prescaler_feed
);
  import cpm_pkg::*;

  always_comb begin
    case (i_pll_power)
      PWR_NORMAL: o_pll_state = PLL_RUN;
      PWR_ASYNC_PD: o_pll_state = PLL_ASYNC_OFF;
      // undescribed codes keep the loop inactive
      default: o_pll_state = PLL_HALTED;
    endcase
  end

  always_comb begin
    if (i_bypass) begin
      o_div_ratio = DIV_RATIO_BYPASS;
    end else begin
      case (i_div_code)
        3'h0: o_div_ratio = DIV_RATIO_DEFAULT;
        3'h1: o_div_ratio = 3'h3;
        3'h2: o_div_ratio = 3'h4;
        3'h3: o_div_ratio = 3'h5;
        3'h4: o_div_ratio = 3'h6;
        default: o_div_ratio = 3'h1;
      endcase
    end
  end

  // vco enters the feedback prescaler only on the divider route
  assign o_prescaler_feed = (o_pll_state == PLL_RUN) && !i_bypass;
endmodule

// *** hw/cpm_clock_path_cfg.sv ***
// Behaviour
// [R01] power field code 01 puts the pll in async power-down, 00 runs it.
// [R02] the pfd polarity bit selects positive (clear) or negative (set).
// [R03] source bit 0 set routes the clock past the vco divider.
// [R04] otherwise the vco divider applies, and code 000 means divide by 2.
// [R05] reset leaves pll powered down, divider code 000, divider in path; a valid nonvolatile image replaces these after release.
// [R06] software keeps sources above the channel limit off the bypass.
// [R07] with pll on and divider routed, the vco feeds the prescaler.
// [R08] settings can be saved to and restored from nonvolatile storage.
// [R09] undescribed power codes leave the pll loop inactive.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module cpm_clock_path_cfg (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [cpm_pkg::APB_AW-1:0] i_paddr,
  input wire logic [cpm_pkg::APB_DW-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [cpm_pkg::APB_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_pll_enable,
  output logic o_pll_power_down,
  output logic o_pll_halted,
  output logic o_pfd_negative,
  output logic o_div_bypass,
  output logic [2:0] o_vco_div_ratio,
  output logic o_prescaler_feed,
  output logic o_nv_busy
);
  import cpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register bus decode

  logic [7:0] reg_pll;
  logic [7:0] reg_div;
  logic [7:0] reg_src;
  logic [7:0] next_reg_pll;
  logic [7:0] next_reg_div;
  logic [7:0] next_reg_src;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic hit_pll;
  logic hit_div;
  logic hit_src;
  logic hit_nv;
  logic mapped;
  logic access;
  logic fire;
  logic wr_fire;
  logic save_req;
  logic load_req;

  cpm_nv_state_t nv_state;
  cpm_nv_state_t next_nv_state;
  logic [1:0] nv_idx;
  logic [1:0] next_nv_idx;
  logic nv_we;
  logic [7:0] nv_wdata;
  logic [7:0] nv_rdata;
  logic nv_valid;
  logic nv_busy;
  logic [7:0] cur_byte;

  assign hit_pll = (i_paddr == ADDR_PLL);
  assign hit_div = (i_paddr == ADDR_DIV);
  assign hit_src = (i_paddr == ADDR_SRC);
  assign hit_nv = (i_paddr == ADDR_NV);
  assign mapped = hit_pll | hit_div | hit_src | hit_nv;
  assign access = i_psel & i_penable;
  assign fire = access & o_pready;
  // only byte lane 0 carries register data
  assign wr_fire = fire & i_pwrite & i_pstrb[0];
  assign save_req = wr_fire & hit_nv & i_pwdata[NV_SAVE_BIT];
  assign load_req = wr_fire & hit_nv & i_pwdata[NV_LOAD_BIT];
  assign nv_busy = (nv_state != NV_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, longer while the store is busy

  always_comb begin
    // stalling rather than refusing keeps saves and writes ordered
    next_pready = access & !o_pready & !nv_busy;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (next_pready) begin
      next_pslverr = !mapped;
      if (!i_pwrite) begin
        if (hit_pll) begin
          next_prdata = {24'h00_0000, reg_pll};
        end else if (hit_div) begin
          next_prdata = {24'h00_0000, reg_div};
        end else if (hit_src) begin
          next_prdata = {24'h00_0000, reg_src};
        end else if (hit_nv) begin
          next_prdata[NV_VALID_BIT] = nv_valid;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
      o_prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // nonvolatile save and restore sequencer

  always_comb begin
    case (nv_idx)
      2'h0: cur_byte = reg_pll;
      2'h1: cur_byte = reg_div;
      default: cur_byte = reg_src;
    endcase
  end

  always_comb begin
    next_nv_state = nv_state;
    next_nv_idx = nv_idx;
    nv_we = 1'b0;
    nv_wdata = 8'h00;
    case (nv_state)
      NV_BOOT: begin
        // a valid image overrides the reset defaults after release
        next_nv_idx = 2'h0;
        next_nv_state = nv_valid ? NV_LOAD : NV_IDLE; // R08
      end
      NV_IDLE: begin
        next_nv_idx = 2'h0;
        if (save_req) begin
          next_nv_state = NV_SAVE; // R08
        end else if (load_req && nv_valid) begin
          next_nv_state = NV_LOAD; // R08
        end
      end
      NV_SAVE: begin
        nv_we = 1'b1;
        // marker goes last, so a partial first image never reads valid; a resave keeps the old marker until its last cycle
        nv_wdata = (nv_idx == NV_MARK_IDX) ? NV_MAGIC : cur_byte;
        if (nv_idx == NV_MARK_IDX) begin
          next_nv_state = NV_IDLE;
          next_nv_idx = 2'h0;
        end else begin
          next_nv_idx = nv_idx + 2'h1;
        end
      end
      NV_LOAD: begin
        if (nv_idx == NV_LAST_CFG) begin
          next_nv_state = NV_IDLE;
          next_nv_idx = 2'h0;
        end else begin
          next_nv_idx = nv_idx + 2'h1;
        end
      end
      default: begin
        next_nv_state = NV_IDLE;
        next_nv_idx = 2'h0;
      end
    endcase
  end

  cpm_nv_store u_store (
    .i_clk_sys(i_clk_sys),
    .i_we(nv_we),
    .i_addr(nv_idx),
    .i_wdata(nv_wdata),
    .o_rdata(nv_rdata),
    .o_valid(nv_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_comb begin
    next_reg_pll = reg_pll;
    next_reg_div = reg_div;
    next_reg_src = reg_src;
    if (nv_state == NV_LOAD) begin
      case (nv_idx)
        2'h0: next_reg_pll = nv_rdata; // R08
        2'h1: next_reg_div = nv_rdata; // R08
        default: next_reg_src = nv_rdata; // R08
      endcase
    end else if (wr_fire) begin
      if (hit_pll) begin
        next_reg_pll = i_pwdata[7:0]; // R01 R02
      end
      if (hit_div) begin
        next_reg_div = i_pwdata[7:0]; // R04
      end
      if (hit_src) begin
        next_reg_src = i_pwdata[7:0]; // R03
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode; outputs track the registers in the same edge

  cpm_pll_state_t dec_state;
  logic [2:0] dec_ratio;
  logic dec_feed;

  cpm_mode_decode u_decode (
    .i_pll_power(next_reg_pll[PLL_PWR_LSB+:2]),
    .i_bypass(next_reg_src[BYPASS_BIT]),
    .i_div_code(next_reg_div[DIV_LSB+:3]),
    .o_pll_state(dec_state),
    .o_div_ratio(dec_ratio),
    .o_prescaler_feed(dec_feed)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      reg_pll <= RST_PLL; // R05
      reg_div <= RST_DIV; // R05
      reg_src <= RST_SRC; // R05
      nv_state <= NV_BOOT;
      nv_idx <= 2'h0;
      o_pll_enable <= 1'b0;
      o_pll_power_down <= 1'b1; // R05
      o_pll_halted <= 1'b0;
      o_pfd_negative <= 1'b0;
      o_div_bypass <= 1'b0; // R05
      o_vco_div_ratio <= DIV_RATIO_DEFAULT; // R05
      o_prescaler_feed <= 1'b0;
      o_nv_busy <= 1'b1;
    end else begin
      reg_pll <= next_reg_pll;
      reg_div <= next_reg_div;
      reg_src <= next_reg_src;
      nv_state <= next_nv_state;
      nv_idx <= next_nv_idx;
      o_pll_enable <= (dec_state == PLL_RUN); // R01
      o_pll_power_down <= (dec_state == PLL_ASYNC_OFF); // R01
      o_pll_halted <= (dec_state == PLL_HALTED); // R09
      o_pfd_negative <= next_reg_pll[PFD_POL_BIT]; // R02
      o_div_bypass <= next_reg_src[BYPASS_BIT]; // R03
      o_vco_div_ratio <= dec_ratio; // R04
      o_prescaler_feed <= dec_feed; // R07
      o_nv_busy <= (next_nv_state != NV_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  property p_pll_power_write;
    wr_fire && hit_pll && (i_pwdata[1:0] == PWR_ASYNC_PD) && !nv_busy
      |=> o_pll_power_down && !o_pll_enable && !o_prescaler_feed;
  endproperty
  a_pll_power_write: assert property (p_pll_power_write) // R01
    else $error("power code 01 did not power the pll down");

  property p_pll_run_code;
    o_pll_enable |-> (reg_pll[1:0] == PWR_NORMAL) && !o_pll_power_down;
  endproperty
  a_pll_run_code: assert property (p_pll_run_code) // R01
    else $error("pll running without code 00");

  property p_pfd_polarity;
    wr_fire && hit_pll && !nv_busy
      |=> o_pfd_negative == $past(i_pwdata[PFD_POL_BIT]);
  endproperty
  a_pfd_polarity: assert property (p_pfd_polarity) // R02
    else $error("pfd polarity does not follow the written bit");

  property p_bypass_route;
    o_div_bypass |-> reg_src[BYPASS_BIT] && o_vco_div_ratio == 3'h1;
  endproperty
  a_bypass_route: assert property (p_bypass_route) // R03
    else $error("bypass output disagrees with source bit");

  property p_div_default;
    !o_div_bypass && (reg_div[2:0] == 3'h0)
      |-> o_vco_div_ratio == DIV_RATIO_DEFAULT;
  endproperty
  a_div_default: assert property (p_div_default) // R04
    else $error("divider code 000 is not divide by two");

  property p_reset_defaults;
    disable iff (1'b0)
    i_reset ##1 !i_reset |-> o_pll_power_down && !o_div_bypass
      && o_vco_div_ratio == DIV_RATIO_DEFAULT && !o_pll_enable;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) // R05
    else $error("reset did not leave the distribution defaults");
  property p_prescaler_feed;
    o_prescaler_feed == (o_pll_enable && !o_div_bypass);
  endproperty
  a_prescaler_feed: assert property (p_prescaler_feed) // R07
    else $error("prescaler feed does not match pll and route");
  property p_save_length;
    $rose(nv_state == NV_SAVE) |-> (nv_state == NV_SAVE) [*4]
      ##1 (nv_state == NV_IDLE) && nv_valid;
  endproperty
  a_save_length: assert property (p_save_length) // R08
    else $error("save did not finish in four cycles with a valid image");
  property p_load_restores;
    // a write with both bits set is a save, which takes longer
    nv_state == NV_IDLE && load_req && !save_req && nv_valid
      |-> ##[3:4] (nv_state == NV_IDLE) && !o_nv_busy;
  endproperty
  a_load_restores: assert property (p_load_restores) // R08
    else $error("restore did not complete in time");
  property p_halted_code;
    reg_pll[1] && !nv_busy
      |-> o_pll_halted && !o_pll_enable && !o_pll_power_down;
  endproperty
  a_halted_code: assert property (p_halted_code) // R09
    else $error("undescribed power code left the loop active");
  property p_stall_busy;
    nv_busy |=> !o_pready;
  endproperty
  a_stall_busy: assert property (p_stall_busy)
    else $error("bus answered while the store was busy");

  c_save: cover property (nv_state == NV_SAVE ##4 nv_state == NV_IDLE);
  c_load: cover property (nv_state == NV_LOAD ##3 nv_state == NV_IDLE);
  c_pll_bypass: cover property (o_pll_enable && o_div_bypass);
  c_bad_addr: cover property (o_pready && o_pslverr);
endmodule

// *** testbench/cpm_vco_model.sv ***
`timescale 1ns/1ns
module cpm_vco_model #(
  parameter int VCO_MHZ = 1200,
  parameter int CHAN_LIMIT_MHZ = 1600,
  parameter int FEED_LIMIT_MHZ = 2400,
  parameter bit RISES_WITH_V = 1'b1
) (
  input wire logic i_clk_sys,
  input wire logic i_pll_enable,
  input wire logic i_pfd_negative,
  input wire logic i_div_bypass,
  input wire logic i_prescaler_feed,
  output logic o_over_limit,
  output logic o_pol_match
);
  // a bypassed source must stay below the channel divider limit
  always_ff @(posedge i_clk_sys) begin
    o_over_limit <= (i_div_bypass && VCO_MHZ >= CHAN_LIMIT_MHZ)
      || (i_prescaler_feed && VCO_MHZ >= FEED_LIMIT_MHZ);
  end
  // loop only locks when detector direction suits this oscillator
  always_ff @(posedge i_clk_sys) begin
    o_pol_match <= !i_pll_enable
      || (i_pfd_negative == !RISES_WITH_V);
  end
endmodule

// *** testbench/cpm_clock_path_cfg_test.sv ***
`timescale 1ns/1ns
module cpm_clock_path_cfg_test;
  import cpm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h00000000;
  logic [3:0] pst = 4'h0;
  logic [31:0] prd;
  logic prdy, perr, en, pd, halt, neg, byp, feed, busy, over, match;
  logic [2:0] ratio;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  cpm_clock_path_cfg cpm_clock_path_cfg_i (.i_clk_sys(clk), .i_reset(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .i_pstrb(pst), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .o_pll_enable(en), .o_pll_power_down(pd),
    .o_pll_halted(halt), .o_pfd_negative(neg), .o_div_bypass(byp),
    .o_vco_div_ratio(ratio), .o_prescaler_feed(feed), .o_nv_busy(busy));
  cpm_vco_model cpm_vco_model_i (.i_clk_sys(clk), .i_pll_enable(en),
    .i_pfd_negative(neg), .i_div_bypass(byp), .i_prescaler_feed(feed),
    .o_over_limit(over), .o_pol_match(match));
  //////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // long enough for every stalled transfer plus both resets
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    pst <= s;
    @(posedge clk);
    pen <= 1'b1;
    // waits out the store sequencer as well as the wait state
    // only the bench timeout ends this wait if pready never rises
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}, 4'hF);
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] d);
    apb(1'b0, a, 32'h00000000, 4'h0);
    check(rd, {24'h000000, d});
  endtask
  // vector: enable, power-down, halted, negative, bypass, ratio, feed
  function automatic logic [8:0] mode(input logic e, p, h, n, b,
      input logic [2:0] r, input logic f);
    return {e, p, h, n, b, r, f};
  endfunction
  function automatic logic [2:0] div_of(input logic [2:0] c);
    return (c <= 3'h4) ? c + 3'h2 : 3'h1;
  endfunction
  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  logic [8:0] seen_mode;
  assign seen_mode = {en, pd, halt, neg, byp, ratio, feed};
  initial begin
    do_reset();
    check(seen_mode, mode(0, 1, 0, 0, 0, 3'h2, 0));
    rdchk(ADDR_PLL, 8'h01);
    rdchk(ADDR_DIV, 8'h00);
    rdchk(ADDR_SRC, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_PLL, {c[0], 5'h00, c[1:0]});
      check(seen_mode, mode(c == 0, c == 1, c >= 2, c[0], 0, 3'h2,
        c == 0));
      // the oscillator model answers one edge after the outputs move
      @(posedge clk);
      check(match, 1'b1);
    end
    wr(ADDR_PLL, 8'h80);
    @(posedge clk);
    check(match, 1'b0);
    wr(ADDR_PLL, 8'h00);
    for (int d = 0; d < 8; d++) begin
      wr(ADDR_DIV, d[7:0]);
      check(seen_mode, mode(1, 0, 0, 0, 0, div_of(d[2:0]), 1));
      rdchk(ADDR_DIV, d[7:0]);
    end
    wr(ADDR_SRC, 8'h01);
    check(seen_mode, mode(1, 0, 0, 0, 1, 3'h1, 0));
    @(posedge clk);
    check(over, 1'b0);
    apb(1'b1, ADDR_PLL, 32'h00000001, 4'h0);
    rdchk(ADDR_PLL, 8'h00);
    apb(1'b1, 12'h044, 32'h000000FF, 4'hF);
    check(er, 1'b1);
    apb(1'b0, 12'h044, 32'h00000000, 4'h0);
    check(er, 1'b1);
    check(rd, 32'h00000000);
    wr(ADDR_NV, 8'h01);
    check(busy, 1'b1);
    apb(1'b0, ADDR_NV, 32'h00000000, 4'h0);
    check(rd & 32'h00000004, 32'h00000004);
    check(busy, 1'b0);
    wr(ADDR_PLL, 8'h81);
    wr(ADDR_NV, 8'h02);
    rdchk(ADDR_PLL, 8'h00);
    wr(ADDR_DIV, 8'h02);
    do_reset();
    rdchk(ADDR_PLL, 8'h00);
    rdchk(ADDR_DIV, 8'h07);
    rdchk(ADDR_SRC, 8'h01);
    check(seen_mode, mode(1, 0, 0, 0, 1, 3'h1, 0));
    end_of_test();
  end
endmodule
